// ---- obdc_defs.vh ----
// Constants for the output bank divider configuration block.
// Assumes it is included by bare name from the design files.
`ifndef OBDC_DEFS_VH
`define OBDC_DEFS_VH

// Register byte addresses.
`define OBDC_ADDR_DIV_CODE 8'h20
`define OBDC_ADDR_RSVD_A 8'h21
`define OBDC_ADDR_BANK_CTL 8'h22
`define OBDC_ADDR_RSVD_B 8'h23
`define OBDC_ADDR_OUT0_CTL 8'h24
`define OBDC_ADDR_OUT1_CTL 8'h25

// Field positions.
`define OBDC_DIV_CODE_MSB 5
`define OBDC_BANK_PD_BIT 7
`define OBDC_BANK_SRC_BIT 0
`define OBDC_OUT_PD_BIT 7
`define OBDC_OUT_STY_BIT 2
`define OBDC_OUT_AMP_MSB 1

// Reset values.
`define OBDC_DIV_CODE_RST 6'h0D
`define OBDC_DIV_RATIO_RST 8'h10
`define OBDC_BANK_PD_RST 1'b0
`define OBDC_BANK_SRC_RST 1'b0
`define OBDC_OUT_PD_RST 2'h0
`define OBDC_OUT_STY_RST 2'h0
`define OBDC_OUT_AMP_RST 4'h0

// Divider code limits and field encodings.
`define OBDC_DIV_CODE_MAX 6'h3B
`define OBDC_SRC_PINS 1'b0
`define OBDC_SRC_REGS 1'b1
`define OBDC_STY_LVDS 1'b0
`define OBDC_STY_ECL 1'b1
`define OBDC_AMP_350MV 2'h0
`define OBDC_AMP_500MV 2'h1
`define OBDC_AMP_750MV 2'h2
`define OBDC_AMP_RSVD 2'h3

`endif

// ---- obdc_int_div.v ----
// Integer divider for one output bank, with glitch-free ratio changes.
// Assumes ratio_load is a one-cycle pulse and ratio_in is nonzero.
`timescale 1ns/1ps
`include "obdc_defs.vh"

module obdc_int_div #(
  parameter W = 8
) (
  sys_clk,
  rst,
  run,
  ratio_load,
  ratio_in,
  div_clk,
  div_tick,
  cur_ratio
);
  input wire sys_clk;
  input wire rst;
  input wire run;
  input wire ratio_load;
  input wire [W-1:0] ratio_in;
  output wire div_clk;
  output wire div_tick;
  output wire [W-1:0] cur_ratio;

  reg [W-1:0] ratio_q;
  reg [W-1:0] ratio_d;
  reg [W-1:0] nxt_q;
  reg pend_q;
  reg [W-1:0] cnt_q;
  reg [W-1:0] cnt_d;
  reg clk_q;
  reg tick_q;
  wire wrap;
  wire [W:0] half_w;

  assign wrap = (cnt_q == ratio_q - {{(W-1){1'b0}}, 1'b1});
  assign half_w = ({1'b0, ratio_d} + {{W{1'b0}}, 1'b1}) >> 1;

  // A new ratio is only adopted at a period boundary, or while stopped,
  // so the running output never shows a shortened high or low phase.
  always @* begin
    ratio_d = ratio_q;
    cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    if (!run) begin
      cnt_d = {W{1'b0}};
      if (pend_q) begin
        ratio_d = nxt_q;
      end
    end else if (wrap) begin
      cnt_d = {W{1'b0}};
      if (pend_q) begin
        ratio_d = nxt_q;
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ratio_q <= `OBDC_DIV_RATIO_RST;
      nxt_q <= `OBDC_DIV_RATIO_RST;
      pend_q <= 1'b0;
      cnt_q <= {W{1'b0}};
      clk_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      cnt_q <= cnt_d;
      if (ratio_load) begin
        nxt_q <= ratio_in;
        pend_q <= 1'b1;
      end else if (!run || wrap) begin
        pend_q <= 1'b0;
      end
      clk_q <= run && ({1'b0, cnt_d} < half_w);
      tick_q <= run && wrap;
    end
  end

  assign div_clk = clk_q;
  assign div_tick = tick_q;
  assign cur_ratio = ratio_q;
endmodule

// ---- obdc_bank_cfg.v ----
// Configuration logic for one integer-divider output bank.
// Assumes a byte register port from the serial interface, synchronous
// inputs, and an initialisation bit held in another register block.
//
// What this block does
// - Decode 6-bit divider code via fixed table.
// - New divider code applies only on init toggle.
// - Bank power-down stops bank and both outputs, in register mode only.
// - Source bit picks control pins or registers.
// - Per-output power-down bit stops that output.
// - Style bit selects LVDS or emitter-coupled format, in register mode only.
// - Amplitude code selects 350, 500, 750 mV, in register mode only.
// - Reserved bits written zero, read as zero.
`timescale 1ns/1ps
`include "obdc_defs.vh"

module obdc_bank_cfg #(
  parameter RW = 8,
  // Four 6-bit codes packed end to end; pin value 0 owns the low field.
  parameter [23:0] PIN_DIV_CODES = 24'h34_A1C4,
  parameter [1:0] PIN_STYLE = 2'h0,
  parameter [3:0] PIN_AMP = 4'h0
) (
  sys_clk,
  rst,
  reg_wr_en,
  reg_rd_en,
  reg_addr,
  reg_wdata,
  reg_rdata,
  bank_ctl_pin,
  init_clk_bit,
  bank_power_down_st,
  output_power_down_st,
  output_style_st,
  output_amplitude_st,
  amp_reserved,
  div_ratio,
  bank_clock_output,
  bank_clock_tick
);
  input wire sys_clk;
  input wire rst;
  input wire reg_wr_en;
  input wire reg_rd_en;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  output wire [7:0] reg_rdata;
  input wire [1:0] bank_ctl_pin;
  input wire init_clk_bit;
  output wire bank_power_down_st;
  output wire [1:0] output_power_down_st;
  output wire [1:0] output_style_st;
  output wire [3:0] output_amplitude_st;
  output wire [1:0] amp_reserved;
  output wire [RW-1:0] div_ratio;
  output wire bank_clock_output;
  output wire bank_clock_tick;

  // Ratio table lookup; zero marks a reserved code.
  function [7:0] obdc_ratio;
    input [5:0] code;
    begin
      case (code)
        6'h01: obdc_ratio = 8'd1;
        6'h02: obdc_ratio = 8'd2;
        6'h03: obdc_ratio = 8'd3;
        6'h04: obdc_ratio = 8'd4;
        6'h05: obdc_ratio = 8'd5;
        6'h06: obdc_ratio = 8'd6;
        6'h07: obdc_ratio = 8'd8;
        6'h08: obdc_ratio = 8'd9;
        6'h09: obdc_ratio = 8'd10;
        6'h0A: obdc_ratio = 8'd12;
        6'h0B: obdc_ratio = 8'd14;
        6'h0C: obdc_ratio = 8'd15;
        6'h0D: obdc_ratio = 8'd16;
        6'h0E: obdc_ratio = 8'd18;
        6'h0F: obdc_ratio = 8'd20;
        6'h10: obdc_ratio = 8'd21;
        6'h11: obdc_ratio = 8'd22;
        6'h12: obdc_ratio = 8'd24;
        6'h13: obdc_ratio = 8'd25;
        6'h14: obdc_ratio = 8'd27;
        6'h15: obdc_ratio = 8'd28;
        6'h16: obdc_ratio = 8'd30;
        6'h17: obdc_ratio = 8'd32;
        6'h18: obdc_ratio = 8'd33;
        6'h19: obdc_ratio = 8'd35;
        6'h1A: obdc_ratio = 8'd36;
        6'h1B: obdc_ratio = 8'd40;
        6'h1C: obdc_ratio = 8'd42;
        6'h1D: obdc_ratio = 8'd44;
        6'h1E: obdc_ratio = 8'd45;
        6'h1F: obdc_ratio = 8'd48;
        6'h20: obdc_ratio = 8'd50;
        6'h21: obdc_ratio = 8'd54;
        6'h22: obdc_ratio = 8'd55;
        6'h23: obdc_ratio = 8'd56;
        6'h24: obdc_ratio = 8'd60;
        6'h25: obdc_ratio = 8'd64;
        6'h26: obdc_ratio = 8'd66;
        6'h27: obdc_ratio = 8'd70;
        6'h28: obdc_ratio = 8'd72;
        6'h29: obdc_ratio = 8'd80;
        6'h2A: obdc_ratio = 8'd84;
        6'h2B: obdc_ratio = 8'd88;
        6'h2C: obdc_ratio = 8'd90;
        6'h2D: obdc_ratio = 8'd96;
        6'h2E: obdc_ratio = 8'd100;
        6'h2F: obdc_ratio = 8'd108;
        6'h30: obdc_ratio = 8'd110;
        6'h31: obdc_ratio = 8'd112;
        6'h32: obdc_ratio = 8'd120;
        6'h33: obdc_ratio = 8'd128;
        6'h34: obdc_ratio = 8'd132;
        6'h35: obdc_ratio = 8'd140;
        6'h36: obdc_ratio = 8'd144;
        6'h37: obdc_ratio = 8'd160;
        6'h38: obdc_ratio = 8'd176;
        6'h39: obdc_ratio = 8'd180;
        6'h3A: obdc_ratio = 8'd200;
        6'h3B: obdc_ratio = 8'd220;
        default: obdc_ratio = 8'd0;
      endcase
    end
  endfunction

  // Software-visible settings.
  reg [5:0] div_code_q;
  reg bank_pd_q;
  reg bank_src_q;
  reg [1:0] out_pd_q;
  reg [1:0] out_sty_q;
  reg [3:0] out_amp_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  // Effective settings after source selection.
  reg [5:0] eff_code;
  reg eff_bank_pd;
  reg [1:0] eff_sty;
  reg [3:0] eff_amp;

  reg st_bank_pd_q;
  reg [1:0] st_out_pd_q;
  reg [1:0] st_sty_q;
  reg [3:0] st_amp_q;
  reg [1:0] st_amp_rsvd_q;

  reg init_prev_q;
  reg init_arm_q;
  wire init_toggle;
  wire [7:0] eff_ratio;
  wire ratio_load;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_code_q <= `OBDC_DIV_CODE_RST;
      bank_pd_q <= `OBDC_BANK_PD_RST;
      bank_src_q <= `OBDC_BANK_SRC_RST;
      out_pd_q <= `OBDC_OUT_PD_RST;
      out_sty_q <= `OBDC_OUT_STY_RST;
      out_amp_q <= `OBDC_OUT_AMP_RST;
    end else if (reg_wr_en) begin
      // Reserved positions are dropped on write.
      case (reg_addr)
        `OBDC_ADDR_DIV_CODE: begin
          div_code_q <= reg_wdata[`OBDC_DIV_CODE_MSB:0];
        end
        `OBDC_ADDR_BANK_CTL: begin
          bank_pd_q <= reg_wdata[`OBDC_BANK_PD_BIT];
          bank_src_q <= reg_wdata[`OBDC_BANK_SRC_BIT];
        end
        `OBDC_ADDR_OUT0_CTL: begin
          out_pd_q[0] <= reg_wdata[`OBDC_OUT_PD_BIT];
          out_sty_q[0] <= reg_wdata[`OBDC_OUT_STY_BIT];
          out_amp_q[1:0] <= reg_wdata[`OBDC_OUT_AMP_MSB:0];
        end
        `OBDC_ADDR_OUT1_CTL: begin
          out_pd_q[1] <= reg_wdata[`OBDC_OUT_PD_BIT];
          out_sty_q[1] <= reg_wdata[`OBDC_OUT_STY_BIT];
          out_amp_q[3:2] <= reg_wdata[`OBDC_OUT_AMP_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Reserved and unmapped positions read as zero.
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `OBDC_ADDR_DIV_CODE: begin
        rdata_d[`OBDC_DIV_CODE_MSB:0] = div_code_q;
      end
      `OBDC_ADDR_BANK_CTL: begin
        rdata_d[`OBDC_BANK_PD_BIT] = bank_pd_q;
        rdata_d[`OBDC_BANK_SRC_BIT] = bank_src_q;
      end
      `OBDC_ADDR_OUT0_CTL: begin
        rdata_d[`OBDC_OUT_PD_BIT] = out_pd_q[0];
        rdata_d[`OBDC_OUT_STY_BIT] = out_sty_q[0];
        rdata_d[`OBDC_OUT_AMP_MSB:0] = out_amp_q[1:0];
      end
      `OBDC_ADDR_OUT1_CTL: begin
        rdata_d[`OBDC_OUT_PD_BIT] = out_pd_q[1];
        rdata_d[`OBDC_OUT_STY_BIT] = out_sty_q[1];
        rdata_d[`OBDC_OUT_AMP_MSB:0] = out_amp_q[3:2];
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_en) begin
      rdata_q <= rdata_d;
    end
  end

  // Pin mode never powers the bank down; registers are still readable.
  always @* begin
    if (bank_src_q == `OBDC_SRC_REGS) begin
      eff_code = div_code_q;
      eff_bank_pd = bank_pd_q;
      eff_sty = out_sty_q;
      eff_amp = out_amp_q;
    end else begin
      case (bank_ctl_pin)
        2'h0: eff_code = PIN_DIV_CODES[5:0];
        2'h1: eff_code = PIN_DIV_CODES[11:6];
        2'h2: eff_code = PIN_DIV_CODES[17:12];
        2'h3: eff_code = PIN_DIV_CODES[23:18];
        default: eff_code = `OBDC_DIV_CODE_RST;
      endcase
      eff_bank_pd = 1'b0;
      eff_sty = PIN_STYLE;
      eff_amp = PIN_AMP;
    end
  end

  // The first sample after reset only arms the detector, so a bit that
  // already sits high at release is not taken for a toggle.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      init_prev_q <= 1'b0;
      init_arm_q <= 1'b0;
    end else begin
      init_prev_q <= init_clk_bit;
      init_arm_q <= 1'b1;
    end
  end

  assign init_toggle = init_arm_q && (init_clk_bit != init_prev_q);
  assign eff_ratio = obdc_ratio(eff_code);
  // A reserved code at the toggle leaves the running ratio in place.
  assign ratio_load = init_toggle && (eff_ratio != 8'd0);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          st_out_pd_q[gi] <= 1'b0;
          st_sty_q[gi] <= `OBDC_STY_LVDS;
          st_amp_q[2*gi+1:2*gi] <= `OBDC_AMP_350MV;
          st_amp_rsvd_q[gi] <= 1'b0;
        end else begin
          // Bank power-down overrides the per-output bit.
          st_out_pd_q[gi] <= eff_bank_pd | out_pd_q[gi];
          st_sty_q[gi] <= eff_sty[gi];
          st_amp_q[2*gi+1:2*gi] <= eff_amp[2*gi+1:2*gi];
          st_amp_rsvd_q[gi] <=
            (eff_amp[2*gi+1:2*gi] == `OBDC_AMP_RSVD);
        end
      end
    end
  endgenerate

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_bank_pd_q <= `OBDC_BANK_PD_RST;
    end else begin
      st_bank_pd_q <= eff_bank_pd;
    end
  end

  obdc_int_div #(
    .W(RW)
  ) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    // Run follows the effective setting itself, so the divided clock stops
    // on the same edge at which the registered power-down status rises.
    .run(~eff_bank_pd),
    .ratio_load(ratio_load),
    .ratio_in(eff_ratio[RW-1:0]),
    .div_clk(bank_clock_output),
    .div_tick(bank_clock_tick),
    .cur_ratio(div_ratio)
  );

  assign reg_rdata = rdata_q;
  assign bank_power_down_st = st_bank_pd_q;
  assign output_power_down_st = st_out_pd_q;
  assign output_style_st = st_sty_q;
  assign output_amplitude_st = st_amp_q;
  assign amp_reserved = st_amp_rsvd_q;
endmodule

// ---- obdc_bank_cfg_sva.sv ----
// Checker for the bank configuration block.
// Assumes it is bound to obdc_bank_cfg and sees only its ports.
`timescale 1ns/1ps
module obdc_bank_cfg_chk #(
  parameter RW = 8
) (
  input wire sys_clk,
  input wire rst,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire [1:0] bank_ctl_pin,
  input wire init_clk_bit,
  input wire bank_power_down_st,
  input wire [1:0] output_power_down_st,
  input wire [1:0] output_style_st,
  input wire [3:0] output_amplitude_st,
  input wire [1:0] amp_reserved,
  input wire [RW-1:0] div_ratio,
  input wire bank_clock_output,
  input wire bank_clock_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence pd_wr_s;
    reg_wr_en && reg_addr == 8'h22 && reg_wdata == 8'h81;
  endsequence
  sequence unmap_rd_s;
    reg_rd_en && (reg_addr < 8'h20 || reg_addr > 8'h25 ||
      reg_addr == 8'h21 || reg_addr == 8'h23);
  endsequence
  pd_write_a: assert property (
    pd_wr_s |-> ##2 bank_power_down_st) else $error("pd write lost");
  clk_off_a: assert property (
    bank_power_down_st |-> !bank_clock_output) else $error("clock on");
  out_pd_a: assert property (
    bank_power_down_st |-> output_power_down_st == 2'h3)
    else $error("outputs not down");
  amp_flag_a: assert property (
    amp_reserved == {&output_amplitude_st[3:2],
      &output_amplitude_st[1:0]}) else $error("amp flag wrong");
  ratio_move_a: assert property (
    !$stable(div_ratio) && !bank_power_down_st |-> bank_clock_tick)
    else $error("ratio moved mid period");
  ratio_range_a: assert property (
    div_ratio >= 1 && div_ratio <= 220) else $error("ratio range");
  rd_unmap_a: assert property (
    unmap_rd_s |=> reg_rdata == 8'h00) else $error("unmapped read");
  rd_code_a: assert property (
    reg_rd_en && reg_addr == 8'h20 |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved bits read");
  tick_pulse_a: assert property (
    bank_clock_tick && div_ratio > 1 |=> !bank_clock_tick)
    else $error("tick too long");
endmodule
bind obdc_bank_cfg obdc_bank_cfg_chk #(.RW(RW)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .bank_ctl_pin(bank_ctl_pin),
  .init_clk_bit(init_clk_bit), .bank_power_down_st(bank_power_down_st),
  .output_power_down_st(output_power_down_st),
  .output_style_st(output_style_st),
  .output_amplitude_st(output_amplitude_st),
  .amp_reserved(amp_reserved), .div_ratio(div_ratio),
  .bank_clock_output(bank_clock_output),
  .bank_clock_tick(bank_clock_tick));

// ---- obdc_host_model.sv ----
// Host and control-pin model driving the bank register port.
// Assumes sys_clk is the design clock; all drives follow a rising edge.
`timescale 1ns/1ps
module obdc_host_model (
  input wire sys_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic [1:0] bank_ctl_pin,
  output logic init_clk_bit
);
  initial begin
    reg_wr_en = 0;
    reg_rd_en = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    bank_ctl_pin = 2'h0;
    init_clk_bit = 0;
  end
  // Idle data is inverted so a stale value can never look valid.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 0;
    reg_wdata <= ~d;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd_en <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 0;
  endtask
  task tog;
    @(posedge sys_clk);
    init_clk_bit <= ~init_clk_bit;
  endtask
  task pins(input logic [1:0] p);
    @(posedge sys_clk);
    bank_ctl_pin <= p;
  endtask
  // Output power-down bits go with the bank power-down.
  task bank_off;
    wr(8'h22, 8'h81);
    wr(8'h24, 8'h80);
    wr(8'h25, 8'h80);
  endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the bank configuration block.
// Assumes the host model drives every design input except sys_clk and rst, which the bench drives.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0;
  logic rst = 1;
  wire wen, ren, ini, bpd, bco, btk;
  wire [7:0] addr, wd, rdat, ratio;
  wire [1:0] pin, opd, sty, ars;
  wire [3:0] amp;
  logic [7:0] exp_q[$];
  logic rd_d = 0;
  int fail_count = 0;
  int n_compared = 0;
  int i;
  logic [1:0] a0, a1;
  logic s0, s1;
  logic [7:0] old;
  logic [5:0] codes[5] = '{6'h05, 6'h0B, 6'h3C, 6'h00, 6'h01};
  logic [7:0] rats[5] = '{8'h05, 8'h0E, 8'h0E, 8'h0E, 8'h01};
  logic [7:0] prat[4] = '{8'h10, 8'h04, 8'h08, 8'h0C};
  always #2 sys_clk = ~sys_clk;
  obdc_bank_cfg u_obdc_bank_cfg (.sys_clk(sys_clk), .rst(rst),
    .reg_wr_en(wen), .reg_rd_en(ren), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdat), .bank_ctl_pin(pin), .init_clk_bit(ini),
    .bank_power_down_st(bpd), .output_power_down_st(opd),
    .output_style_st(sty), .output_amplitude_st(amp),
    .amp_reserved(ars), .div_ratio(ratio),
    .bank_clock_output(bco), .bank_clock_tick(btk));
  obdc_host_model u_obdc_host_model (.sys_clk(sys_clk),
    .reg_wr_en(wen), .reg_rd_en(ren), .reg_addr(addr), .reg_wdata(wd),
    .bank_ctl_pin(pin), .init_clk_bit(ini));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_obdc_host_model.rd(a);
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    if (rd_d)
      chk("reg_rdata", exp_q.pop_front(), rdat);
    rd_d <= ren;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    results;
  end
  initial begin
    void'($urandom(36));
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    rd(8'h20, 8'h0D);
    rd(8'h22, 8'h00);
    rd(8'h24, 8'h00);
    wt(1);
    chk("div_ratio", 8'h10, ratio);
    $display("reset test done");
    // Pin values 3, 0, 1, 2 in turn, so the run ends on ratio 12.
    for (i = 0; i < 4; i++) begin
      u_obdc_host_model.pins(2'((i + 3) % 4));
      u_obdc_host_model.tog;
      wt(20);
      chk("div_ratio", prat[i], ratio);
    end
    old = 8'h0C;
    $display("pin test done");
    u_obdc_host_model.wr(8'h22, 8'h01);
    for (i = 0; i < 5; i++) begin
      u_obdc_host_model.wr(8'h20, {2'h0, codes[i]});
      rd(8'h20, {2'h0, codes[i]});
      wt(8);
      chk("div_ratio", old, ratio);
      u_obdc_host_model.tog;
      wt(old + 4);
      chk("div_ratio", rats[i], ratio);
      old = rats[i];
    end
    chk("clk_out", 8'h01, {7'h00, bco});
    chk("clk_tick", 8'h01, {7'h00, btk});
    $display("divider test done");
    for (i = 0; i < 4; i++) begin
      a0 = $urandom % 4;
      a1 = (i == 0) ? 2'h3 : $urandom % 4;
      s0 = $urandom % 2;
      s1 = $urandom % 2;
      u_obdc_host_model.wr(8'h24, {5'h00, s0, a0});
      u_obdc_host_model.wr(8'h25, {5'h00, s1, a1});
      wt(3);
      chk("style", {6'h00, s1, s0}, {6'h00, sty});
      chk("amp", {4'h0, a1, a0}, {4'h0, amp});
      chk("amp_rsvd", {6'h00, a1 == 3, a0 == 3}, {6'h00, ars});
      rd(8'h25, {5'h00, s1, a1});
    end
    $display("output format test done");
    u_obdc_host_model.wr(8'h24, 8'h80);
    wt(3);
    chk("out_pd", 8'h01, {6'h00, opd});
    chk("bank_pd", 8'h00, {7'h00, bpd});
    u_obdc_host_model.bank_off;
    wt(3);
    chk("bank_pd", 8'h01, {7'h00, bpd});
    chk("out_pd", 8'h03, {6'h00, opd});
    chk("clk_out", 8'h00, {7'h00, bco});
    rd(8'h22, 8'h81);
    rd(8'h21, 8'h00);
    rd(8'h23, 8'h00);
    rd(8'h40, 8'h00);
    wt(4);
    $display("power-down test done");
    results;
  end
endmodule
